// *** hdl/fblm_ecc_map.sv ***
// ecc ram packing: item index to word address and byte lane, combinational
module fblm_ecc_map
    import fblm_pkg::*;
(
    input  fblm_pkg::fblm_kind_t     kind,
    input  wire logic [8:0]          index,
    input  wire logic                sel,
    output logic                     err,
    output logic [FBLM_ERAM_W-1:0]   addr,
    output logic [1:0]               lane
);
    logic [8:0] rel;

    always_comb begin
        err  = 1'b0;
        addr = '0;
        lane = 2'h0;
        rel  = '0;
        unique case (kind)
            FBLM_K_PSYN: begin
                // sel picks s1 over s0
                if (index >= FBLM_P_PAIRS) begin
                    err = 1'b1;
                end else begin
                    addr = FBLM_E_PQ_BASE + {index[7:0], 2'h0};
                    lane = {1'b1, sel};
                end
            end
            FBLM_K_QSYN: begin
                if (index >= FBLM_Q_PAIRS) begin
                    err = 1'b1;
                end else begin
                    addr = FBLM_E_PQ_BASE + {index[7:0], 2'h0};
                    lane = {1'b0, sel};
                end
            end
            FBLM_K_FLAG: begin
                if (index >= FBLM_FLAG_CNT) begin
                    err = 1'b1;
                end else if (index < FBLM_FLAG_LO) begin
                    // two per word, sharing with upper p syndromes
                    addr = FBLM_E_PF_BASE + {1'b0, index[7:1], 2'h0};
                    lane = {1'b0, index[0]};
                end else if (index < FBLM_FLAG_F4END) begin
                    rel  = index - FBLM_FLAG_LO;
                    addr = FBLM_E_F4_BASE + {1'b0, rel[8:2], 2'h0};
                    lane = rel[1:0];
                end else begin
                    // upper two lanes of this word stay unused
                    addr = FBLM_E_FT_ADDR;
                    lane = {1'b0, index[0]};
                end
            end
            FBLM_K_CREM: begin
                err  = index >= FBLM_CREM_CNT;
                addr = FBLM_E_CREM_ADDR;
                lane = index[1:0];
            end
            FBLM_K_HDR: begin
                err  = index >= FBLM_HDR_CNT;
                addr = FBLM_E_HDR_ADDR;
                lane = index[1:0];
            end
            FBLM_K_EREG: begin
                err  = index >= FBLM_EREG_CNT;
                addr = FBLM_E_REG_BASE + {2'h0, index[7:2], 2'h0};
                lane = index[1:0];
            end
            default: begin
                err = 1'b1;
            end
        endcase
    end
endmodule

// *** hdl/fblm_pkg.sv ***
// package: frame slot layout and ecc ram packing constants and carriers
package fblm_pkg;
    localparam int unsigned FBLM_ADDR_W = 22;
    localparam int unsigned FBLM_OFF_W  = 12;
    localparam int unsigned FBLM_ERAM_W = 10;

    // frame slot field starts and lengths in bytes
    localparam logic [11:0] FBLM_SYNC_OFF  = 12'h000;
    localparam logic [11:0] FBLM_SYNC_LEN  = 12'h00C;
    localparam logic [11:0] FBLM_HDR_OFF   = 12'h00C;
    localparam logic [11:0] FBLM_HDR_LEN   = 12'h004;
    localparam logic [11:0] FBLM_DATA_OFF  = 12'h010;
    localparam logic [11:0] FBLM_DATA_LEN  = 12'h800;
    localparam logic [11:0] FBLM_CRC_OFF   = 12'h810;
    localparam logic [11:0] FBLM_CRC_LEN   = 12'h004;
    localparam logic [11:0] FBLM_PAD_OFF   = 12'h814;
    localparam logic [11:0] FBLM_PAD_LEN   = 12'h008;
    localparam logic [11:0] FBLM_PPAR_OFF  = 12'h81C;
    localparam logic [11:0] FBLM_PPAR_LEN  = 12'h0AC;
    localparam logic [11:0] FBLM_QPAR_OFF  = 12'h8C8;
    localparam logic [11:0] FBLM_QPAR_LEN  = 12'h068;
    localparam logic [11:0] FBLM_QCH_OFF   = 12'h930;
    localparam logic [11:0] FBLM_QCH_LEN   = 12'h010;
    localparam logic [11:0] FBLM_SUB_OFF   = 12'h940;
    localparam logic [11:0] FBLM_SUB_LEN   = 12'h060;
    localparam logic [11:0] FBLM_FLAG_OFF  = 12'h9A0;
    localparam logic [11:0] FBLM_FLAG_LEN  = 12'h126;
    localparam logic [11:0] FBLM_CREM_OFF  = 12'hAC6;
    localparam logic [11:0] FBLM_CREM_LEN  = 12'h004;
    localparam logic [11:0] FBLM_PSYN_OFF  = 12'hACA;
    localparam logic [11:0] FBLM_PSYN_LEN  = 12'h0AC;
    localparam logic [11:0] FBLM_QSYN_OFF  = 12'hB76;
    localparam logic [11:0] FBLM_QSYN_LEN  = 12'h068;
    localparam logic [11:0] FBLM_STAT_OFF  = 12'hBDE;
    localparam logic [11:0] FBLM_STAT_LEN  = 12'h001;
    localparam logic [11:0] FBLM_SLOT_LEN  = 12'hBDF;

    // ecc ram word byte addresses
    localparam logic [9:0] FBLM_E_PQ_BASE   = 10'h000;
    localparam logic [9:0] FBLM_E_PF_BASE   = 10'h0D0;
    localparam logic [9:0] FBLM_E_F4_BASE   = 10'h158;
    localparam logic [9:0] FBLM_E_FT_ADDR   = 10'h238;
    localparam logic [9:0] FBLM_E_CREM_ADDR = 10'h23C;
    localparam logic [9:0] FBLM_E_HDR_ADDR  = 10'h240;
    localparam logic [9:0] FBLM_E_REG_BASE  = 10'h244;

    // index limits
    localparam logic [8:0] FBLM_PQ_PAIRS   = 9'h034;
    localparam logic [8:0] FBLM_P_PAIRS    = 9'h056;
    localparam logic [8:0] FBLM_Q_PAIRS    = 9'h034;
    localparam logic [8:0] FBLM_FLAG_LO    = 9'h044;
    localparam logic [8:0] FBLM_FLAG_F4END = 9'h124;
    localparam logic [8:0] FBLM_FLAG_CNT   = 9'h126;
    localparam logic [8:0] FBLM_HDR_CNT    = 9'h004;
    localparam logic [8:0] FBLM_CREM_CNT   = 9'h004;
    localparam logic [8:0] FBLM_EREG_CNT   = 9'h040;

    typedef enum logic [3:0] {
        FBLM_F_SYNC, FBLM_F_HDR, FBLM_F_DATA, FBLM_F_CRC, FBLM_F_PAD,
        FBLM_F_PPAR, FBLM_F_QPAR, FBLM_F_QCH, FBLM_F_SUB, FBLM_F_FLAG,
        FBLM_F_CREM, FBLM_F_PSYN, FBLM_F_QSYN, FBLM_F_STAT
    } fblm_field_t;

    // ecc ram item kinds
    typedef enum logic [2:0] {
        FBLM_K_PSYN, FBLM_K_QSYN, FBLM_K_FLAG, FBLM_K_CREM, FBLM_K_HDR, FBLM_K_EREG
    } fblm_kind_t;

    typedef struct packed {
        logic                      valid;
        logic [10:0]               slot;
        fblm_field_t               field;
        logic [FBLM_OFF_W-1:0]     index;
    } fblm_buf_req_t;

    typedef struct packed {
        logic                      valid;
        logic                      err;
        logic [FBLM_ADDR_W-1:0]    addr;
        logic [FBLM_OFF_W-1:0]     offset;
    } fblm_buf_rsp_t;

    typedef struct packed {
        logic                      valid;
        fblm_kind_t                kind;
        logic [8:0]                index;
        logic                      sel;
    } fblm_ecc_req_t;

    typedef struct packed {
        logic                      valid;
        logic                      err;
        logic [FBLM_ERAM_W-1:0]    addr;
        logic [1:0]                lane;
    } fblm_ecc_rsp_t;
endpackage

// *** hdl/fblm_top.sv ***
// frame buffer slot address generator and ecc ram word mapper
// Operation
// - slot bytes 0..11 hold the twelve-byte sync field.
// - slot bytes 12..15 hold the four header bytes.
// - slot bytes 16..2063 hold the 2048 user data bytes.
// - slot bytes 2064..2067 hold four crc parity bytes.
// - slot bytes 2068..2075 are eight padding bytes.
// - slot bytes 2076..2247 hold 172 p parity bytes.
// - slot bytes 2248..2351 hold 104 q parity bytes.
// - slot bytes 2352..2367 hold sixteen q subcode bytes.
// - slot bytes 2368..2463 hold 96 sub-channel bytes.
// - slot bytes 2464..2757 hold 294 error flag bytes.
// - slot bytes 2758..2761 hold the crc remainder.
// - slot bytes 2762..2933 hold 172 p syndrome bytes.
// - slot bytes 2934..3037 hold 104 q syndrome bytes.
// - status byte at 3038; slot is 3039 bytes long.
// - ecc words 0x000..0x0CC pack p pair high, q pair low, pairs 0..51.
// - ecc words 0x0D0..0x154 pack p pairs 52..85 high, flags 0..67 low.
// - ecc words 0x158..0x234 hold four flags each, 68..291, lowest in lane 0.
// - ecc word 0x238 holds flags 292,293 in lanes 0,1; upper lanes unused.
// - ecc word 0x23C holds crc remainder byte n in lane n.
// - ecc word 0x240 holds header byte n in lane n.
// - ecc working registers four per word from 0x244, index mod four is lane.
module fblm_top
    import fblm_pkg::*;
#(
    parameter logic [FBLM_ADDR_W-1:0] BUF_BASE = '0
)
(
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  fblm_pkg::fblm_buf_req_t  buf_req,
    output fblm_pkg::fblm_buf_rsp_t  buf_rsp,
    input  fblm_pkg::fblm_ecc_req_t  ecc_req,
    output fblm_pkg::fblm_ecc_rsp_t  ecc_rsp
);
    import fblm_pkg::*;

    typedef struct packed {
        fblm_buf_rsp_t buf_rsp;
        fblm_ecc_rsp_t ecc_rsp;
    } fblm_state_t;

    fblm_state_t state_reg;
    fblm_state_t state_next;

    logic [11:0]            fld_off;
    logic [11:0]            fld_len;
    logic                   ecc_err;
    logic [FBLM_ERAM_W-1:0] ecc_addr;
    logic [1:0]             ecc_lane;
    logic [FBLM_ADDR_W-1:0] slot_base;
    logic [11:0]            byte_off;

    always_comb begin
        fld_off = FBLM_SYNC_OFF;
        fld_len = FBLM_SYNC_LEN;
        unique case (buf_req.field)
            FBLM_F_SYNC: begin
                fld_off = FBLM_SYNC_OFF;
                fld_len = FBLM_SYNC_LEN;
            end
            FBLM_F_HDR: begin
                fld_off = FBLM_HDR_OFF;
                fld_len = FBLM_HDR_LEN;
            end
            FBLM_F_DATA: begin
                fld_off = FBLM_DATA_OFF;
                fld_len = FBLM_DATA_LEN;
            end
            FBLM_F_CRC: begin
                fld_off = FBLM_CRC_OFF;
                fld_len = FBLM_CRC_LEN;
            end
            FBLM_F_PAD: begin
                fld_off = FBLM_PAD_OFF;
                fld_len = FBLM_PAD_LEN;
            end
            FBLM_F_PPAR: begin
                fld_off = FBLM_PPAR_OFF;
                fld_len = FBLM_PPAR_LEN;
            end
            FBLM_F_QPAR: begin
                fld_off = FBLM_QPAR_OFF;
                fld_len = FBLM_QPAR_LEN;
            end
            FBLM_F_QCH: begin
                fld_off = FBLM_QCH_OFF;
                fld_len = FBLM_QCH_LEN;
            end
            FBLM_F_SUB: begin
                fld_off = FBLM_SUB_OFF;
                fld_len = FBLM_SUB_LEN;
            end
            FBLM_F_FLAG: begin
                fld_off = FBLM_FLAG_OFF;
                fld_len = FBLM_FLAG_LEN;
            end
            FBLM_F_CREM: begin
                fld_off = FBLM_CREM_OFF;
                fld_len = FBLM_CREM_LEN;
            end
            FBLM_F_PSYN: begin
                fld_off = FBLM_PSYN_OFF;
                fld_len = FBLM_PSYN_LEN;
            end
            FBLM_F_QSYN: begin
                fld_off = FBLM_QSYN_OFF;
                fld_len = FBLM_QSYN_LEN;
            end
            FBLM_F_STAT: begin
                fld_off = FBLM_STAT_OFF;
                fld_len = FBLM_STAT_LEN;
            end
            default: begin
                fld_off = FBLM_SYNC_OFF;
                fld_len = 12'h000;
            end
        endcase
    end

    fblm_ecc_map u_ecc_map (
        .kind  (ecc_req.kind),
        .index (ecc_req.index),
        .sel   (ecc_req.sel),
        .err   (ecc_err),
        .addr  (ecc_addr),
        .lane  (ecc_lane)
    );

    // slots packed back to back; product widened first, wraps at the address width
    assign slot_base = BUF_BASE + FBLM_ADDR_W'(buf_req.slot) * FBLM_ADDR_W'(FBLM_SLOT_LEN);
    assign byte_off  = fld_off + buf_req.index;

    always_comb begin
        state_next = state_reg;
        state_next.buf_rsp.valid = buf_req.valid;
        state_next.ecc_rsp.valid = ecc_req.valid;
        if (buf_req.valid) begin
            // index beyond the field is flagged, address still formed
            state_next.buf_rsp.err    = buf_req.index >= fld_len;
            state_next.buf_rsp.offset = byte_off;
            state_next.buf_rsp.addr   = slot_base + FBLM_ADDR_W'(byte_off);
        end
        if (ecc_req.valid) begin
            state_next.ecc_rsp.err  = ecc_err;
            state_next.ecc_rsp.addr = ecc_addr;
            state_next.ecc_rsp.lane = ecc_lane;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign buf_rsp = state_reg.buf_rsp;
    assign ecc_rsp = state_reg.ecc_rsp;
endmodule

// *** sim/fblm_checker.sv ***
// concurrent checks on the layout mapper ports
module fblm_checker
    import fblm_pkg::*;
#(
    parameter logic [FBLM_ADDR_W-1:0] BUF_BASE = '0
)
(
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  fblm_pkg::fblm_buf_req_t  buf_req,
    input  fblm_pkg::fblm_buf_rsp_t  buf_rsp,
    input  fblm_pkg::fblm_ecc_req_t  ecc_req,
    input  fblm_pkg::fblm_ecc_rsp_t  ecc_rsp
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] OFF [14] = '{12'h000, 12'h00C, 12'h010, 12'h810, 12'h814, 12'h81C, 12'h8C8,
        12'h930, 12'h940, 12'h9A0, 12'hAC6, 12'hACA, 12'hB76, 12'hBDE};
    localparam logic [11:0] LEN [14] = '{12'h00C, 12'h004, 12'h800, 12'h004, 12'h008, 12'h0AC, 12'h068,
        12'h010, 12'h060, 12'h126, 12'h004, 12'h0AC, 12'h068, 12'h001};
    logic [21:0] exp_addr;
    logic        exp_err;
    logic [8:0]  d;
    logic [9:0]  pq_addr;
    logic [9:0]  fl_addr;
    logic [9:0]  f4_addr;
    logic [9:0]  er_addr;
    logic [1:0]  idx_lo;
    logic [1:0]  d_lo;
    // expected values only from the slot layout, never from the design outputs
    assign exp_addr = BUF_BASE + 22'(buf_req.slot) * 22'd3039 + 22'(OFF[buf_req.field]) + 22'(buf_req.index);
    assign exp_err  = buf_req.index >= LEN[buf_req.field];
    assign d        = ecc_req.index - 9'd68;
    assign pq_addr  = 10'({ecc_req.index, 2'b00});
    assign fl_addr  = 10'h0D0 + 10'({ecc_req.index[8:1], 2'b00});
    assign f4_addr  = 10'h158 + 10'({d[8:2], 2'b00});
    assign er_addr  = 10'h244 + 10'({ecc_req.index[8:2], 2'b00});
    assign idx_lo   = ecc_req.index[1:0];
    assign d_lo     = d[1:0];
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    buf_valid_a: assert property (buf_rsp.valid == $past(buf_req.valid))
        else $error("buffer answer latency wrong");
    buf_addr_a: assert property (buf_req.valid |=> buf_rsp.addr == $past(exp_addr))
        else $error("buffer address wrong");
    buf_err_a: assert property (buf_req.valid |=> buf_rsp.err == $past(exp_err))
        else $error("buffer range flag wrong");
    ecc_valid_a: assert property (ecc_rsp.valid == $past(ecc_req.valid))
        else $error("ecc answer latency wrong");
    psyn_pack_a: assert property (ecc_req.valid && ecc_req.kind == FBLM_K_PSYN && ecc_req.index < 9'd86 |=>
        !ecc_rsp.err && ecc_rsp.addr == $past(pq_addr) && ecc_rsp.lane == {1'b1, $past(ecc_req.sel)})
        else $error("p syndrome packing wrong");
    qsyn_pack_a: assert property (ecc_req.valid && ecc_req.kind == FBLM_K_QSYN && ecc_req.index < 9'd52 |=>
        !ecc_rsp.err && ecc_rsp.addr == $past(pq_addr) && ecc_rsp.lane == {1'b0, $past(ecc_req.sel)})
        else $error("q syndrome packing wrong");
    flag_pair_a: assert property (ecc_req.valid && ecc_req.kind == FBLM_K_FLAG && ecc_req.index < 9'd68 |=>
        ecc_rsp.addr == $past(fl_addr) && ecc_rsp.lane == {1'b0, $past(idx_lo[0])})
        else $error("flag pair packing wrong");
    flag_quad_a: assert property (ecc_req.valid && ecc_req.kind == FBLM_K_FLAG &&
        ecc_req.index inside {[68:291]} |=> ecc_rsp.addr == $past(f4_addr) && ecc_rsp.lane == $past(d_lo))
        else $error("flag quad packing wrong");
    flag_range_a: assert property (ecc_req.valid && ecc_req.kind == FBLM_K_FLAG &&
        ecc_req.index >= 9'd294 |=> ecc_rsp.err) else $error("flag range not refused");
    ereg_pack_a: assert property (ecc_req.valid && ecc_req.kind == FBLM_K_EREG && ecc_req.index < 9'd64 |=>
        ecc_rsp.addr == $past(er_addr) && ecc_rsp.lane == $past(idx_lo))
        else $error("working register packing wrong");
    crem_pack_a: assert property (ecc_req.valid && ecc_req.kind == FBLM_K_CREM && ecc_req.index < 9'd4 |=>
        !ecc_rsp.err && ecc_rsp.addr == 10'h23C && ecc_rsp.lane == $past(idx_lo))
        else $error("crc remainder packing wrong");
    hdr_pack_a: assert property (ecc_req.valid && ecc_req.kind == FBLM_K_HDR && ecc_req.index < 9'd4 |=>
        !ecc_rsp.err && ecc_rsp.addr == 10'h240 && ecc_rsp.lane == $past(idx_lo))
        else $error("header packing wrong");
endmodule
bind fblm_top fblm_checker #(.BUF_BASE(BUF_BASE)) i_chk (.clock, .sys_rst, .buf_req, .buf_rsp, .ecc_req, .ecc_rsp);

// *** sim/fblm_client.sv ***
// request-side client model for the layout mapper
module fblm_client
    import fblm_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic                go,
    input  fblm_pkg::fblm_buf_req_t  buf_cmd,
    input  fblm_pkg::fblm_ecc_req_t  ecc_cmd,
    output fblm_pkg::fblm_buf_req_t  buf_req,
    output fblm_pkg::fblm_ecc_req_t  ecc_req
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle fields flip each cycle so a stale value never looks like a request
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            buf_req <= '0;
            ecc_req <= '0;
        end else if (go) begin
            buf_req <= buf_cmd;
            ecc_req <= ecc_cmd;
        end else begin
            buf_req <= {1'b0, ~buf_req[$bits(buf_req)-2:0]};
            ecc_req <= {1'b0, ~ecc_req[$bits(ecc_req)-2:0]};
        end
    end
endmodule

// *** sim/fblm_top_bench.sv ***
// self-checking bench for the layout mapper
module fblm_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import fblm_pkg::*;
    localparam logic [21:0] BASE = 22'h010000;
    localparam logic [11:0] OFF [14] = '{12'h000, 12'h00C, 12'h010, 12'h810, 12'h814, 12'h81C, 12'h8C8,
        12'h930, 12'h940, 12'h9A0, 12'hAC6, 12'hACA, 12'hB76, 12'hBDE};
    localparam logic [11:0] LEN [14] = '{12'h00C, 12'h004, 12'h800, 12'h004, 12'h008, 12'h0AC, 12'h068,
        12'h010, 12'h060, 12'h126, 12'h004, 12'h0AC, 12'h068, 12'h001};
    logic          clock   = 1'b0;
    logic          sys_rst = 1'b1;
    logic          go      = 1'b0;
    fblm_buf_req_t buf_cmd = '0;
    fblm_ecc_req_t ecc_cmd = '0;
    fblm_buf_req_t buf_req;
    fblm_ecc_req_t ecc_req;
    fblm_buf_rsp_t buf_rsp;
    fblm_ecc_rsp_t ecc_rsp;
    int            fail_count   = 0;
    int            total_checks = 0;
    int            cycles       = 0;

    always #12.5 clock = ~clock;

    fblm_client i_client (.clock, .sys_rst, .go, .buf_cmd, .ecc_cmd, .buf_req, .ecc_req);
    fblm_top #(.BUF_BASE(BASE)) i_dut (.clock, .sys_rst, .buf_req, .buf_rsp, .ecc_req, .ecc_rsp);

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // client registers the command, the mapper answers one edge later
    task automatic issue(input fblm_buf_req_t b, input fblm_ecc_req_t e);
        buf_cmd = b;
        ecc_cmd = e;
        go = 1'b1;
        @(posedge clock);
        #1 go = 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic t_buf();
        logic [11:0] idx;
        logic [10:0] slot;
        for (int f = 0; f < 14; f++) begin
            for (int k = 0; k < 3; k++) begin
                idx = (k == 0) ? 12'h000 : (k == 1) ? LEN[f] - 12'h001 : LEN[f];
                slot = 11'h003 + 11'(f * 97);
                issue('{1'b1, slot, fblm_field_t'(f), idx}, '0);
                check(32'(buf_rsp.valid), 32'h1);
                check(32'(buf_rsp.err), 32'(k == 2));
                check(32'(buf_rsp.offset), 32'(OFF[f] + idx));
                check(32'(buf_rsp.addr), 32'(BASE + 22'(slot) * 22'd3039 + 22'(OFF[f]) + 22'(idx)));
            end
        end
        $display("test buf_fields done");
    endtask

    task automatic ecc(input fblm_kind_t k, input logic [8:0] i, input logic s, input logic [9:0] a,
        input logic [1:0] l, input logic er);
        issue('0, '{1'b1, k, i, s});
        check(32'(ecc_rsp.valid), 32'h1);
        check(32'(ecc_rsp.err), 32'(er));
        check(32'(ecc_rsp.addr), 32'(a));
        check(32'(ecc_rsp.lane), 32'(l));
    endtask

    // reset in mid-run clears the standing answers at once and keeps them clear
    task automatic t_reset();
        issue('{1'b1, 11'h001, FBLM_F_DATA, 12'h005}, '{1'b1, FBLM_K_HDR, 9'd1, 1'b0});
        sys_rst = 1'b1;
        #1;
        check(32'(buf_rsp.valid), 32'h0);
        check(32'(buf_rsp.addr), 32'h0);
        check(32'(ecc_rsp.addr), 32'h0);
        @(posedge clock);
        #1 sys_rst = 1'b0;
        @(posedge clock);
        #1;
        check(32'(buf_rsp.valid), 32'h0);
        check(32'(ecc_rsp.valid), 32'h0);
        $display("test mid_reset done");
    endtask

    task automatic t_ecc();
        ecc(FBLM_K_PSYN, 9'd0, 1'b1, 10'h000, 2'd3, 1'b0);
        ecc(FBLM_K_QSYN, 9'd51, 1'b1, 10'h0CC, 2'd1, 1'b0);
        ecc(FBLM_K_QSYN, 9'd52, 1'b0, 10'h000, 2'd0, 1'b1);
        ecc(FBLM_K_PSYN, 9'd85, 1'b0, 10'h154, 2'd2, 1'b0);
        ecc(FBLM_K_PSYN, 9'd86, 1'b0, 10'h000, 2'd0, 1'b1);
        ecc(FBLM_K_FLAG, 9'd0, 1'b0, 10'h0D0, 2'd0, 1'b0);
        ecc(FBLM_K_FLAG, 9'd67, 1'b0, 10'h154, 2'd1, 1'b0);
        ecc(FBLM_K_FLAG, 9'd68, 1'b0, 10'h158, 2'd0, 1'b0);
        ecc(FBLM_K_FLAG, 9'd291, 1'b0, 10'h234, 2'd3, 1'b0);
        ecc(FBLM_K_FLAG, 9'd292, 1'b0, 10'h238, 2'd0, 1'b0);
        ecc(FBLM_K_FLAG, 9'd293, 1'b1, 10'h238, 2'd1, 1'b0);
        ecc(FBLM_K_FLAG, 9'd294, 1'b0, 10'h000, 2'd0, 1'b1);
        ecc(FBLM_K_CREM, 9'd3, 1'b0, 10'h23C, 2'd3, 1'b0);
        ecc(FBLM_K_HDR, 9'd2, 1'b0, 10'h240, 2'd2, 1'b0);
        ecc(FBLM_K_EREG, 9'd7, 1'b0, 10'h248, 2'd3, 1'b0);
        ecc(FBLM_K_EREG, 9'd10, 1'b0, 10'h24C, 2'd2, 1'b0);
        $display("test ecc_packing done");
    endtask

    // ceiling well above the roughly 130 cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        repeat (10) @(posedge clock);
        #1 sys_rst = 1'b0;
        @(posedge clock);
        #1;
        t_buf();
        t_reset();
        t_ecc();
        summarize();
    end
endmodule
